// >>> verilog/ssb_pkg.sv
package ssb_pkg;

  // ---------------------------------------------------------------
  // Scratchpad offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] SSB_OFS_TEMP_LO   = 4'h0;
  localparam logic [3:0] SSB_OFS_TEMP_HI   = 4'h1;
  localparam logic [3:0] SSB_OFS_FLAGS     = 4'h2;
  localparam logic [3:0] SSB_OFS_RSV3      = 4'h3;
  localparam logic [3:0] SSB_OFS_SETUP1    = 4'h4;
  localparam logic [3:0] SSB_OFS_SETUP2    = 4'h5;
  localparam logic [3:0] SSB_OFS_QUICK_ID  = 4'h6;
  localparam logic [3:0] SSB_OFS_RSV7      = 4'h7;
  localparam logic [3:0] SSB_OFS_LLIM_LO   = 4'h8;
  localparam logic [3:0] SSB_OFS_LLIM_HI   = 4'h9;
  localparam logic [3:0] SSB_OFS_ULIM_LO   = 4'ha;
  localparam logic [3:0] SSB_OFS_ULIM_HI   = 4'hb;
  localparam logic [3:0] SSB_OFS_CORR_LO   = 4'hc;
  localparam logic [3:0] SSB_OFS_CORR_HI   = 4'hd;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  SSB_RST_TEMP     = 8'h00;
  localparam logic [7:0]  SSB_RST_SETUP1   = 8'h70;
  localparam logic [7:0]  SSB_RST_SETUP2   = 8'h80;
  localparam logic [7:0]  SSB_RST_QUICK_ID = 8'h00;
  localparam logic [15:0] SSB_RST_LLIM     = 16'h0000;
  localparam logic [15:0] SSB_RST_ULIM     = 16'h07f0;
  localparam logic [15:0] SSB_RST_CORR     = 16'h0000;
  localparam logic [7:0]  SSB_RST_PIN_SAMP = 8'hf0;
  localparam logic [7:0]  SSB_RST_PIN_SET  = 8'h00;
  localparam logic [7:0]  SSB_RSV_READ     = 8'hff;
  localparam logic [1:0]  SSB_FLAG_RSV     = 2'h3;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SSB_BIT_ALERT_HI  = 7;
  localparam int SSB_BIT_ALERT_LO  = 6;
  localparam int SSB_BIT_FRESH     = 3;
  localparam int SSB_BIT_SUPPLY    = 2;
  localparam int SSB_BIT_DISCOVERY = 1;
  localparam int SSB_BIT_LOCK      = 0;
  // Alert mode select in setup byte one: 0 latching, 1 comparator
  localparam int SSB_BIT_ALERT_MODE = 4;
  // Discovery select field in setup byte two
  localparam int SSB_DSEL_LSB = 0;
  localparam int SSB_DSEL_W   = 2;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] ofs;
    logic [7:0] wdata;
  } ssb_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } ssb_conv_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] setup1;
    logic [7:0] setup2;
  } ssb_load_t;

endpackage

// >>> verilog/ssb_bank.sv
// What this block does
// - Result bytes read zero after power-up until the first conversion finishes.
// - Latest 16-bit result: low byte offset 00h, high byte 01h, read-only.
// - Flag bit 7 set when result is at or above the upper limit.
// - Flag bit 6 set when result is at or below the lower limit.
// - Alert flags update on each new result; cleared by a flag byte read.
// - In latching mode a set alert flag holds until the flag byte is read.
// - Flag bit 3 set on result update, cleared by a flag byte read.
// - Flag bit 2 shows supply source, sampled at each bus reset when the synchronizer is steady; the power-up sample always reads 0.
// - Flag bit 1 set after address sent in discovery; cleared with discovery_select.
// - Flag bit 0 set once config is locked; then setup writes are refused.
// - Limits reset: lower 0000h, upper F0h low byte and 07h high byte.
// - Setup byte one at 04h resets 70h; setup byte two at 05h resets 80h.
// - Pin registers have no offset: sample byte RO reset F0h, setup WO reset 00h.
// - Correction value bytes at 0Ch and 0Dh, read/write, reset zero.
// - Quick select id byte at 06h, read/write, reset zero.
// - Setup bytes reload from the configuration store on each cfg_load strobe, even when locked.
`timescale 1ns/1ps
`default_nettype none
module ssb_bank
  import ssb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire ssb_req_t   req,
  output logic [7:0]      rdata,
  input  wire ssb_conv_t  conv,
  input  wire ssb_load_t  cfg_load,
  input  wire logic       bus_reset,
  input  wire logic       supply_bus_pin,
  input  wire logic       addr_sent,
  input  wire logic       lock_set,
  input  wire logic       pin_sample_strobe,
  input  wire logic [7:0] pin_levels,
  input  wire logic       pin_setup_wr,
  input  wire logic [7:0] pin_setup_data,
  output logic [7:0]      pin_sample_value,
  output logic [7:0]      pin_setup_value,
  output logic [7:0]      setup_byte_one,
  output logic [7:0]      setup_byte_two,
  output logic [15:0]     correction,
  output logic [7:0]      quick_select_id
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] temp_reg;
  logic [15:0] llim_reg;
  logic [15:0] ulim_reg;
  logic [15:0] corr_reg;
  logic [7:0]  setup1_reg;
  logic [7:0]  setup2_reg;
  logic [7:0]  qid_reg;
  logic        alert_hi_reg;
  logic        alert_lo_reg;
  logic        fresh_result_flag;
  logic        supply_reg;
  logic        discovery_complete_flag;
  logic        lock_reg;
  logic [2:0]  supply_sync_reg;
  logic        sampled_reg;
  logic [7:0]  pin_samp_reg;
  logic [7:0]  pin_set_reg;
  logic [7:0]  rdata_reg;
  logic        flag_read;
  logic        hi_hit;
  logic        lo_hit;
  logic [SSB_DSEL_W-1:0] discovery_select;

  function automatic logic wr_at(input ssb_req_t r, input logic [3:0] o);
    return r.wr && (r.ofs == o);
  endfunction

  assign flag_read        = req.rd && (req.ofs == SSB_OFS_FLAGS);
  assign hi_hit           = $signed(conv.value) >= $signed(ulim_reg);
  assign lo_hit           = $signed(conv.value) <= $signed(llim_reg);
  assign discovery_select = setup2_reg[SSB_DSEL_LSB +: SSB_DSEL_W];

  // ---------------------------------------------------------------
  // Conversion result
  // ---------------------------------------------------------------
  // Only the conversion port writes here; host writes fall away
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_reg <= {SSB_RST_TEMP, SSB_RST_TEMP};
    end else if (conv.valid) begin
      temp_reg <= conv.value;
    end
  end

  // ---------------------------------------------------------------
  // Alert and fresh flags
  // ---------------------------------------------------------------
  // A new result in the read cycle wins over the clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_hi_reg      <= 1'b0;
      alert_lo_reg      <= 1'b0;
      fresh_result_flag <= 1'b0;
    end else begin
      if (conv.valid) begin
        fresh_result_flag <= 1'b1;
        if (setup1_reg[SSB_BIT_ALERT_MODE]) begin
          alert_hi_reg <= hi_hit;
          alert_lo_reg <= lo_hit;
        end else begin
          // Set wins over a same-cycle read; an earlier alert is not lost
          alert_hi_reg <= hi_hit | alert_hi_reg;
          alert_lo_reg <= lo_hit | alert_lo_reg;
        end
      end else if (flag_read) begin
        fresh_result_flag <= 1'b0;
        alert_hi_reg      <= 1'b0;
        alert_lo_reg      <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Supply source
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_sync_reg <= 3'h0;
    end else begin
      supply_sync_reg <= {supply_sync_reg[1:0], supply_bus_pin};
    end
  end

  // First sample after release stands in for power-up detection
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_reg  <= 1'b0;
      sampled_reg <= 1'b0;
    end else if (!sampled_reg || bus_reset) begin
      sampled_reg <= 1'b1;
      if (supply_sync_reg[2] == supply_sync_reg[1]) begin
        supply_reg <= supply_sync_reg[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Discovery and lock
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      discovery_complete_flag <= 1'b0;
    end else if (addr_sent) begin
      discovery_complete_flag <= 1'b1;
    end else if (discovery_select == '0) begin
      discovery_complete_flag <= 1'b0;
    end
  end

  // Lock is sticky; only a power-on reset undoes it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_reg <= 1'b0;
    end else if (lock_set) begin
      lock_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Setup bytes
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      setup1_reg <= SSB_RST_SETUP1;
      setup2_reg <= SSB_RST_SETUP2;
    end else if (cfg_load.valid) begin
      setup1_reg <= cfg_load.setup1;
      setup2_reg <= cfg_load.setup2;
    end else if (!lock_reg) begin
      if (wr_at(req, SSB_OFS_SETUP1)) begin
        setup1_reg <= req.wdata;
      end
      if (wr_at(req, SSB_OFS_SETUP2)) begin
        setup2_reg <= req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Limits, correction, quick id
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      llim_reg <= SSB_RST_LLIM;
      ulim_reg <= SSB_RST_ULIM;
      corr_reg <= SSB_RST_CORR;
      qid_reg  <= SSB_RST_QUICK_ID;
    end else if (req.wr) begin
      case (req.ofs)
        SSB_OFS_LLIM_LO:  llim_reg[7:0]  <= req.wdata;
        SSB_OFS_LLIM_HI:  llim_reg[15:8] <= req.wdata;
        SSB_OFS_ULIM_LO:  ulim_reg[7:0]  <= req.wdata;
        SSB_OFS_ULIM_HI:  ulim_reg[15:8] <= req.wdata;
        SSB_OFS_CORR_LO:  corr_reg[7:0]  <= req.wdata;
        SSB_OFS_CORR_HI:  corr_reg[15:8] <= req.wdata;
        SSB_OFS_QUICK_ID: qid_reg        <= req.wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin registers
  // ---------------------------------------------------------------
  // Pin levels arrive already synchronised with the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_samp_reg <= SSB_RST_PIN_SAMP;
      pin_set_reg  <= SSB_RST_PIN_SET;
    end else begin
      if (pin_sample_strobe) begin
        pin_samp_reg <= pin_levels;
      end
      if (pin_setup_wr) begin
        pin_set_reg <= pin_setup_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (req.rd) begin
      case (req.ofs)
        SSB_OFS_TEMP_LO:  rdata_reg <= temp_reg[7:0];
        SSB_OFS_TEMP_HI:  rdata_reg <= temp_reg[15:8];
        SSB_OFS_FLAGS:    rdata_reg <= {alert_hi_reg, alert_lo_reg, SSB_FLAG_RSV,
                                        fresh_result_flag, supply_reg,
                                        discovery_complete_flag, lock_reg};
        SSB_OFS_SETUP1:   rdata_reg <= setup1_reg;
        SSB_OFS_SETUP2:   rdata_reg <= setup2_reg;
        SSB_OFS_QUICK_ID: rdata_reg <= qid_reg;
        SSB_OFS_LLIM_LO:  rdata_reg <= llim_reg[7:0];
        SSB_OFS_LLIM_HI:  rdata_reg <= llim_reg[15:8];
        SSB_OFS_ULIM_LO:  rdata_reg <= ulim_reg[7:0];
        SSB_OFS_ULIM_HI:  rdata_reg <= ulim_reg[15:8];
        SSB_OFS_CORR_LO:  rdata_reg <= corr_reg[7:0];
        SSB_OFS_CORR_HI:  rdata_reg <= corr_reg[15:8];
        default:          rdata_reg <= SSB_RSV_READ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_sample_value <= SSB_RST_PIN_SAMP;
      pin_setup_value  <= SSB_RST_PIN_SET;
      setup_byte_one   <= SSB_RST_SETUP1;
      setup_byte_two   <= SSB_RST_SETUP2;
      correction       <= SSB_RST_CORR;
      quick_select_id  <= SSB_RST_QUICK_ID;
    end else begin
      pin_sample_value <= pin_samp_reg;
      pin_setup_value  <= pin_set_reg;
      setup_byte_one   <= setup1_reg;
      setup_byte_two   <= setup2_reg;
      correction       <= corr_reg;
      quick_select_id  <= qid_reg;
    end
  end

  assign rdata = rdata_reg;

endmodule
`default_nettype wire

// >>> verif/ssb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssb_host_model
  import ssb_pkg::*;
(
  input  wire logic [7:0] rdata,
  input  wire logic       clk,
  output var  ssb_req_t   req
);
  // -------------------------------------------------
  // Scratchpad access, one-cycle strobes
  // -------------------------------------------------
  initial req = '0;

  // Idle bus shows inverted leftovers so nothing stale looks valid
  task automatic write(input logic [3:0] o, input logic [7:0] x);
    @(posedge clk) #1 req = {2'h2, o, x};
    @(posedge clk) #1 req = {2'h0, ~o, ~x};
  endtask

  task automatic read(input logic [3:0] o, output logic [7:0] x);
    @(posedge clk) #1 req = {2'h1, o, req.wdata};
    @(posedge clk) #1 req = {2'h0, ~o, ~req.wdata};
    x = rdata;
  endtask
endmodule
`default_nettype wire

// >>> verif/ssb_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ssb_bank_assertions
  import ssb_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire ssb_req_t   req,
  input wire logic [7:0] rdata,
  input wire ssb_conv_t  conv,
  input wire ssb_load_t  cfg_load,
  input wire logic       lock_set,
  input wire logic [7:0] setup_byte_one
);
  // -------------------------------------------------
  // Checks
  // -------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [15:0] last_reg;
  logic        lock_reg;
  wire logic   rd_flags = req.rd && req.ofs == SSB_OFS_FLAGS && !conv.valid;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) last_reg <= 16'h0000;
    else if (conv.valid) last_reg <= conv.value;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) lock_reg <= 1'b0;
    else if (lock_set) lock_reg <= 1'b1;
  end

  a_rsv_reads_ff: assert property (req.rd && req.ofs inside {4'h3, 4'h7, 4'he, 4'hf}
    |=> rdata == 8'hff) else $error("reserved read not ff");
  a_temp_low_read: assert property (req.rd && req.ofs == 4'h0 && !conv.valid
    |=> rdata == last_reg[7:0]) else $error("result low byte wrong");
  a_temp_high_read: assert property (req.rd && req.ofs == 4'h1 && !conv.valid
    |=> rdata == last_reg[15:8]) else $error("result high byte wrong");
  a_flags_read_clear: assert property (rd_flags ##1 !conv.valid ##1 rd_flags
    |=> rdata[7:6] == 2'h0 && !rdata[3] && rdata[5:4] == 2'h3) else $error("flags not cleared");
  a_fresh_after_conv: assert property (conv.valid ##1 !req.rd ##1 rd_flags |=> rdata[3])
    else $error("fresh flag missing");
  a_lock_holds_setup: assert property (lock_reg && req.wr && req.ofs == 4'h4 && !cfg_load.valid
    |=> ##1 setup_byte_one == $past(setup_byte_one)) else $error("locked setup changed");
  a_setup_write_lands: assert property (!lock_reg && req.wr && req.ofs == 4'h4 && !cfg_load.valid
    |=> ##1 setup_byte_one == $past(req.wdata, 2)) else $error("setup write lost");
  a_load_restores: assert property (cfg_load.valid
    |=> ##1 setup_byte_one == $past(cfg_load.setup1, 2)) else $error("setup reload lost");
  a_rdata_holds: assert property (!req.rd |=> $stable(rdata)) else $error("rdata moved");

  c_flag_read: cover property (rd_flags);
  c_conv_seen: cover property (conv.valid);
  c_locked_write: cover property (lock_reg && req.wr && req.ofs == 4'h4);
endmodule
`default_nettype wire

// >>> verif/ssb_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module ssb_bank_bench
  import ssb_pkg::*;
;
  // -------------------------------------------------
  // Stimulus and expectations
  // -------------------------------------------------
  logic        clk, sys_rst, bus_reset, supply_bus_pin, addr_sent, lock_set;
  logic        pin_sample_strobe, pin_setup_wr, ah, al, fr, sup, dis, lk;
  logic [7:0]  rdata, pin_levels, pin_setup_data, pin_sample_value, pin_setup_value, d;
  logic [7:0]  setup_byte_one, setup_byte_two, quick_select_id, mem [16];
  logic [15:0] correction;
  logic [31:0] v, seed = 32'h00005cf5;
  ssb_req_t    req;
  ssb_conv_t   conv;
  ssb_load_t   cfg_load;
  int          errors, total_checks;

  ssb_host_model host (.*);
  ssb_bank uut (.*);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Read-only, reserved, or setup while locked
  function automatic logic ro_ofs(input logic [3:0] o);
    return o < 4'h4 || o == 4'h7 || o > 4'hd || (lk && o inside {4'h4, 4'h5});
  endfunction

  task automatic wr(input logic [3:0] o, input logic [7:0] x);
    host.write(o, x);
    if (!ro_ofs(o)) mem[o] = x;
    if (!ro_ofs(o) && o == 4'h5 && x[1:0] == 2'h0) dis = 1'b0;
  endtask

  task automatic rd(input logic [3:0] o);
    host.read(o, d);
    if (o == 4'h2) begin
      `CHK(d, {ah, al, 2'h3, fr, sup, dis, lk})
      {ah, al, fr} = 3'h0;
    end else begin
      `CHK(d, mem[o])
    end
  endtask

  task automatic pulse(ref logic s);
    @(posedge clk) #1 s = 1'b1;
    @(posedge clk) #1 s = 1'b0;
  endtask

  // Latching mode keeps an alert that a later result no longer earns
  task automatic cnv(input logic [15:0] x);
    @(posedge clk) #1 conv = {1'b1, x};
    @(posedge clk) #1 conv = {1'b0, ~x};
    mem[0] = x[7:0];
    mem[1] = x[15:8];
    fr = 1'b1;
    ah = ($signed(x) >= $signed({mem[11], mem[10]})) | (ah & !mem[4][4]);
    al = ($signed(x) <= $signed({mem[9], mem[8]})) | (al & !mem[4][4]);
  endtask

  task automatic summarize();
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #200000;
    errors++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    {conv, cfg_load, pin_levels, pin_setup_data} = '0;
    {bus_reset, supply_bus_pin, addr_sent, lock_set, pin_sample_strobe, pin_setup_wr} = '0;
    {ah, al, fr, sup, dis, lk} = '0;
    mem = '{8'h00, 8'h00, 8'h30, 8'hff, 8'h70, 8'h80, 8'h00, 8'hff,
            8'h00, 8'h00, 8'hf0, 8'h07, 8'h00, 8'h00, 8'hff, 8'hff};
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    `CHK({pin_sample_value, pin_setup_value}, 16'hf000)
    for (int i = 0; i < 16; i++) rd(i[3:0]);
    for (int i = 0; i < 48; i++) begin
      v = rnd();
      wr(v[3:0], v[11:4]);
      rd(v[3:0]);
    end
    `CHK({setup_byte_one, setup_byte_two, correction, quick_select_id},
         {mem[4], mem[5], mem[13], mem[12], mem[6]})
    for (int i = 0; i < 24; i++) begin
      v = rnd();
      wr(4'h4, {3'h3, i[0], 4'h0});
      cnv(i < 2 ? {mem[11], mem[10]} : (i < 4 ? {mem[9], mem[8]} : v[15:0]));
      if (i[1]) cnv(v[31:16]);
      rd(4'h2);
      rd(4'h2);
      rd(4'h0);
      rd(4'h1);
    end
    v = rnd();
    @(posedge clk) #1 cfg_load = {1'b1, v[15:0]};
    @(posedge clk) #1 cfg_load = {1'b0, ~v[15:0]};
    mem[4] = v[15:8];
    mem[5] = v[7:0];
    rd(4'h4);
    rd(4'h5);
    supply_bus_pin = 1'b1;
    repeat (4) @(posedge clk);
    pulse(bus_reset);
    sup = 1'b1;
    rd(4'h2);
    wr(4'h5, 8'h81);
    pulse(addr_sent);
    dis = 1'b1;
    rd(4'h2);
    wr(4'h5, 8'h80);
    rd(4'h2);
    pulse(lock_set);
    lk = 1'b1;
    wr(4'h4, ~mem[4]);
    wr(4'h5, ~mem[5]);
    rd(4'h4);
    rd(4'h5);
    rd(4'h2);
    v = rnd();
    pin_levels = v[7:0];
    pin_setup_data = v[15:8];
    @(posedge clk) #1 {pin_sample_strobe, pin_setup_wr} = 2'h3;
    @(posedge clk) #1 {pin_sample_strobe, pin_setup_wr} = 2'h0;
    pin_levels = ~v[7:0];
    repeat (2) @(posedge clk);
    #1 `CHK({pin_sample_value, pin_setup_value}, {v[7:0], v[15:8]})
    summarize();
  end
endmodule
bind ssb_bank ssb_bank_assertions chk (.*);
`default_nettype wire
